// ---- rtl/owd_map.svh ----
`ifndef OWD_MAP_SVH
`define OWD_MAP_SVH
`define OWD_REG_WDOG_TIMEOUT   16'h07D0
`define OWD_REG_FAULT_MODE     16'h07D2
`define OWD_REG_FAIL_REASON    16'h07D4
`define OWD_REG_COMMAND        16'h07D6
`define OWD_REG_STATUS         16'h1F3C
`define OWD_REG_OUT_DATA       16'h2328
`define OWD_RST_WDOG_TIMEOUT   16'h0000
`define OWD_RST_FAULT_MODE     16'h0000
`define OWD_RST_FAIL_REASON    16'h0000
`define OWD_CMD_SET_FAIL_BIT   4
`define OWD_CMD_ACK_FAIL_BIT   5
`define OWD_CMD_CLR_WARN_BIT   7
`define OWD_STS_ERROR_BIT      0
`define OWD_STS_NETFAIL_BIT    1
`define OWD_CLK_HZ             20000000
`define OWD_MS_PER_S           1000
`define OWD_CYC_PER_MS         (`OWD_CLK_HZ / `OWD_MS_PER_S)
`define OWD_TIMEOUT_MIN_MS     200
`define OWD_TIMEOUT_MAX_MS     65000
`endif

// ---- rtl/owd_pkg.sv ----
package owd_pkg;
  typedef enum logic [15:0] {
    OWD_RSN_NONE       = 16'h0000,
    OWD_RSN_XFER_TMO   = 16'h0007,
    OWD_RSN_HOST_TMO   = 16'h0008,
    OWD_RSN_USER       = 16'h0009,
    OWD_RSN_CONN_ABORT = 16'h000A,
    OWD_RSN_INIT_ERR   = 16'h000B,
    OWD_RSN_WDOG       = 16'h000C,
    OWD_RSN_CONN_TMO   = 16'h000D
  } owd_reason_t;

  typedef enum logic [1:0] {
    OWD_MODE_LOW  = 2'h0,
    OWD_MODE_HIGH = 2'h1,
    OWD_MODE_HOLD = 2'h2
  } owd_mode_t;

  typedef enum logic [1:0] {
    OWD_ST_IDLE  = 2'b00,
    OWD_ST_ARMED = 2'b01,
    OWD_ST_FAIL  = 2'b11
  } owd_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } owd_req_t;

  typedef struct packed {
    logic conn_abort;
    logic init_err;
    logic conn_tmo;
    logic xfer_tmo;
    logic host_tmo;
  } owd_evt_t;
endpackage : owd_pkg

// ---- rtl/owd_output_watchdog.sv ----
`timescale 1ns/1ps
`include "owd_map.svh"
module owd_output_watchdog
  import owd_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `OWD_CYC_PER_MS,
  parameter int          OUT_W      = 8
)(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire owd_req_t         req,
  input  wire logic             auto_confirm,
  input  wire owd_evt_t         evt,
  input  wire logic [15:0]      diag_bits,
  input  wire logic             io_warn_set,
  output logic [15:0]           rdata,
  output logic                  rvalid,
  output logic                  access_err,
  output logic                  io_warn,
  output logic [OUT_W-1:0]      out_pins
);

  logic [15:0]       wdog_timeout_ff;
  logic [1:0]        fault_mode_ff;
  owd_reason_t       reason_ff;
  owd_state_t        state_ff;
  logic [15:0]       ms_cnt_ff;
  logic [31:0]       tick_cnt_ff;
  logic              net_fail_ff;
  logic              warn_ff;
  logic [OUT_W-1:0]  out_data_ff;
  logic [OUT_W-1:0]  hold_ff;
  logic [OUT_W-1:0]  out_ff;
  logic [15:0]       rdata_ff;
  logic              rvalid_ff;
  logic              err_ff;
  logic [15:0]       diag_s1_ff;
  logic [15:0]       diag_s2_ff;
  logic              warn_s1_ff;
  logic              warn_s2_ff;

  logic              wr_tmo;
  logic              wr_mode;
  logic              wr_cmd;
  logic              wr_out;
  logic              rd_cmd;
  logic              wr_ro;
  logic              cmd_onehot;
  logic              cmd_known;
  logic              cmd_legal;
  logic              cmd_set;
  logic              cmd_ack;
  logic              cmd_clr;
  logic              ms_tick;
  logic              wdog_expire;
  logic              wdog_restart;
  logic              ext_fail;
  logic              fail_clear;
  logic              diag_err;
  owd_reason_t       nxt_reason;

  assign wr_tmo  = req.wr && (req.addr == `OWD_REG_WDOG_TIMEOUT);
  assign wr_mode = req.wr && (req.addr == `OWD_REG_FAULT_MODE);
  assign wr_cmd  = req.wr && (req.addr == `OWD_REG_COMMAND);
  assign wr_out  = req.wr && (req.addr == `OWD_REG_OUT_DATA);
  assign rd_cmd  = req.rd && (req.addr == `OWD_REG_COMMAND);
  assign wr_ro   = req.wr && ((req.addr == `OWD_REG_FAIL_REASON) ||
                              (req.addr == `OWD_REG_STATUS));

  // exactly one bit, and it must be a defined command
  assign cmd_onehot = (req.wdata != 16'h0000) &&
                      ((req.wdata & (req.wdata - 16'h0001)) == 16'h0000);
  assign cmd_known  = req.wdata[`OWD_CMD_SET_FAIL_BIT] ||
                      req.wdata[`OWD_CMD_ACK_FAIL_BIT] ||
                      req.wdata[`OWD_CMD_CLR_WARN_BIT];
  assign cmd_legal  = wr_cmd && cmd_onehot && cmd_known;
  assign cmd_set = cmd_legal && req.wdata[`OWD_CMD_SET_FAIL_BIT];
  assign cmd_ack = cmd_legal && req.wdata[`OWD_CMD_ACK_FAIL_BIT];
  assign cmd_clr = cmd_legal && req.wdata[`OWD_CMD_CLR_WARN_BIT];

  // two-flop synchroniser for the asynchronous diagnostic levels
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      diag_s1_ff <= 16'h0000;
      diag_s2_ff <= 16'h0000;
    end
    else
    begin
      diag_s1_ff <= diag_bits;
      diag_s2_ff <= diag_s1_ff;
    end
  end

  // two-flop synchroniser for the asynchronous warning level
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      warn_s1_ff <= 1'b0;
      warn_s2_ff <= 1'b0;
    end
    else
    begin
      warn_s1_ff <= io_warn_set;
      warn_s2_ff <= warn_s1_ff;
    end
  end

  // any synchronised diagnostic bit counts as an error
  assign diag_err = |diag_s2_ff;

  // watchdog timeout in milliseconds; zero keeps the watchdog off
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      wdog_timeout_ff <= `OWD_RST_WDOG_TIMEOUT;
    else if (wr_tmo)
      wdog_timeout_ff <= req.wdata;
  end

  // fault response mode; codes above hold are ignored
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      fault_mode_ff <= 2'(`OWD_RST_FAULT_MODE);
    else if (wr_mode && (req.wdata <= 16'h0002))
      fault_mode_ff <= req.wdata[1:0];
  end

  // millisecond tick
  assign ms_tick = (tick_cnt_ff == (CYC_PER_MS - 1));
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || wdog_restart || (state_ff != OWD_ST_ARMED))
      tick_cnt_ff <= 32'h0000_0000;
    else if (ms_tick)
      tick_cnt_ff <= 32'h0000_0000;
    else
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
  end

  // an output write or an acknowledge restarts the count
  assign wdog_restart = wr_out || cmd_ack;
  assign fail_clear   = cmd_ack || (auto_confirm && wr_out);

  assign wdog_expire = (state_ff == OWD_ST_ARMED) && ms_tick &&
                       !wdog_restart &&
                       ((ms_cnt_ff + 16'h0001) >= wdog_timeout_ff);

  assign ext_fail = evt.conn_abort || evt.init_err || evt.conn_tmo ||
                    evt.xfer_tmo || evt.host_tmo;

  // watchdog state; output writes and the acknowledge command retrigger, reads never do
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_ff  <= OWD_ST_IDLE;
      ms_cnt_ff <= 16'h0000;
    end
    else
    begin
      case (state_ff)
        OWD_ST_IDLE:
        begin
          ms_cnt_ff <= 16'h0000;
          if (wr_out && (wdog_timeout_ff != 16'h0000))
            state_ff <= OWD_ST_ARMED;
        end
        OWD_ST_ARMED:
        begin
          if (wdog_timeout_ff == 16'h0000)
            state_ff <= OWD_ST_IDLE;
          else if (wdog_restart)
            ms_cnt_ff <= 16'h0000;
          else if (wdog_expire)
            state_ff <= OWD_ST_FAIL;
          else if (ms_tick)
            ms_cnt_ff <= ms_cnt_ff + 16'h0001;
        end
        OWD_ST_FAIL:
        begin
          ms_cnt_ff <= 16'h0000;
          if (fail_clear)
            state_ff <= (wdog_timeout_ff != 16'h0000) ? OWD_ST_ARMED : OWD_ST_IDLE;
        end
        default:
          state_ff <= OWD_ST_IDLE;
      endcase
    end
  end

  // network failure flag; a new cause wins over a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      net_fail_ff <= 1'b0;
    else if (wdog_expire || cmd_set || ext_fail)
      net_fail_ff <= 1'b1;
    else if (fail_clear)
      net_fail_ff <= 1'b0;
  end

  // latest cause by fixed priority, one per cycle
  always_comb
  begin
    nxt_reason = reason_ff;
    if (evt.init_err)
      nxt_reason = OWD_RSN_INIT_ERR;
    else if (evt.conn_abort)
      nxt_reason = OWD_RSN_CONN_ABORT;
    else if (evt.xfer_tmo)
      nxt_reason = OWD_RSN_XFER_TMO;
    else if (evt.host_tmo)
      nxt_reason = OWD_RSN_HOST_TMO;
    else if (evt.conn_tmo)
      nxt_reason = OWD_RSN_CONN_TMO;
    else if (wdog_expire)
      nxt_reason = OWD_RSN_WDOG;
    else if (cmd_set)
      nxt_reason = OWD_RSN_USER;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      reason_ff <= OWD_RSN_NONE;
    else
      reason_ff <= nxt_reason;
  end

  // latched I/O warning; a new warning wins over the clear command
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      warn_ff <= 1'b0;
    else if (warn_s2_ff)
      warn_ff <= 1'b1;
    else if (cmd_clr)
      warn_ff <= 1'b0;
  end

  // output process data as last written by the client
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      out_data_ff <= '0;
    else if (wr_out)
      out_data_ff <= req.wdata[OUT_W-1:0];
  end

  // snapshot frozen while the failure lasts, for the hold response
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      hold_ff <= '0;
    else if (!net_fail_ff)
      hold_ff <= out_data_ff;
  end

  // output drive, substitute values while the network failure stands
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      out_ff <= '0;
    else if (!net_fail_ff)
      out_ff <= out_data_ff;
    else
    begin
      case (fault_mode_ff)
        OWD_MODE_LOW:  out_ff <= '0;
        OWD_MODE_HIGH: out_ff <= '1;
        OWD_MODE_HOLD: out_ff <= hold_ff;
        default:       out_ff <= '0;
      endcase
    end
  end

  // read answer strobe, one cycle after the request
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rvalid_ff <= 1'b0;
    else
      rvalid_ff <= req.rd;
  end

  // refused accesses: bad command word, command read, read-only write
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      err_ff <= 1'b0;
    else
      err_ff <= (wr_cmd && !cmd_legal) || rd_cmd || wr_ro;
  end

  // read data; the command register and unmapped numbers read as zero
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rdata_ff <= 16'h0000;
    else if (req.rd)
    begin
      case (req.addr)
        `OWD_REG_WDOG_TIMEOUT: rdata_ff <= wdog_timeout_ff;
        `OWD_REG_FAULT_MODE:   rdata_ff <= {14'h0000, fault_mode_ff};
        `OWD_REG_FAIL_REASON:  rdata_ff <= reason_ff;
        `OWD_REG_STATUS:
          rdata_ff <= {14'h0000, net_fail_ff,
                       diag_err || warn_ff || net_fail_ff};
        `OWD_REG_OUT_DATA:     rdata_ff <= {{(16-OUT_W){1'b0}}, out_data_ff};
        default:               rdata_ff <= 16'h0000;
      endcase
    end
  end

  assign rdata      = rdata_ff;
  assign rvalid     = rvalid_ff;
  assign access_err = err_ff;
  assign io_warn    = warn_ff;
  assign out_pins   = out_ff;

endmodule : owd_output_watchdog

// ---- verification/owd_output_watchdog_sva.sv ----
`timescale 1ns/1ps
`include "owd_map.svh"
module owd_output_watchdog_sva
  import owd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire owd_req_t    req,
  input wire logic        io_warn_set,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        access_err,
  input wire logic        io_warn
);
  logic wr_cmd;
  assign wr_cmd = req.wr && req.addr == `OWD_REG_COMMAND;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  rd_answer_a: assert property (rvalid == $past(req.rd))
    else $error("read answer misplaced");
  cmd_read_a: assert property (
    req.rd && req.addr == `OWD_REG_COMMAND |=> access_err && rdata == 16'h0000)
    else $error("command read not refused");
  ro_write_a: assert property (
    req.wr && (req.addr == `OWD_REG_FAIL_REASON || req.addr == `OWD_REG_STATUS) |=> access_err)
    else $error("read-only write not refused");
  multi_bit_a: assert property (wr_cmd && !$onehot(req.wdata) |=> access_err)
    else $error("multi-bit command not refused");
  reserved_cmd_a: assert property (
    wr_cmd && (req.wdata & 16'hFF4F) != 16'h0000 |=> access_err)
    else $error("reserved command not refused");
  good_write_a: assert property (
    req.wr && !req.rd && req.addr == `OWD_REG_WDOG_TIMEOUT |=> !access_err)
    else $error("timeout write refused");
  warn_clear_a: assert property (wr_cmd && req.wdata == 16'h0080 && !io_warn_set
    && !$past(io_warn_set) && !$past(io_warn_set, 2) && !$past(io_warn_set, 3) |=> !io_warn)
    else $error("warning not cleared");
  rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without read");
  status_rsvd_a: assert property (
    req.rd && !req.wr && req.addr == `OWD_REG_STATUS |=> rdata[15:2] == 14'h0000)
    else $error("reserved status bits set");
  reason_code_a: assert property (req.rd && !req.wr && req.addr == `OWD_REG_FAIL_REASON
    |=> rdata == 16'h0000 || (rdata >= 16'h0007 && rdata <= 16'h000D))
    else $error("reason code out of range");
endmodule : owd_output_watchdog_sva

bind owd_output_watchdog owd_output_watchdog_sva u_owd_output_watchdog_sva (
  .ref_clk(ref_clk), .rstn(rstn), .req(req), .io_warn_set(io_warn_set), .rdata(rdata),
  .rvalid(rvalid), .access_err(access_err), .io_warn(io_warn));

// ---- verification/owd_cli.sv ----
`timescale 1ns/1ps
module owd_cli
  import owd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  input  wire logic        access_err,
  output owd_req_t         req
);
  initial req = '0;
  // timeout words go out as binary ms counts, commands as one bit each
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic v, output logic e);
    @(posedge ref_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
    q = rdata;
    v = rvalid;
    e = access_err;
  endtask : xfer
endmodule : owd_cli

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`include "owd_map.svh"
module tb;
  import owd_pkg::*;
  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] q;
    logic        e;
  } owd_row_t;
  localparam logic [15:0] a_tmo = `OWD_REG_WDOG_TIMEOUT;
  localparam logic [15:0] a_mode = `OWD_REG_FAULT_MODE;
  localparam logic [15:0] a_rsn = `OWD_REG_FAIL_REASON;
  localparam logic [15:0] a_cmd = `OWD_REG_COMMAND;
  localparam logic [15:0] a_sts = `OWD_REG_STATUS;
  localparam logic [15:0] a_out = `OWD_REG_OUT_DATA;
  logic        ref_clk;
  logic        rstn;
  logic        auto_confirm;
  owd_evt_t    evt;
  logic [15:0] diag_bits;
  logic        io_warn_set;
  owd_req_t    req;
  logic [15:0] rdata;
  logic        rvalid;
  logic        access_err;
  logic        io_warn;
  logic [7:0]  out_pins;
  int          errors;
  int          num_checks;
  int          n;
  logic [15:0] q;
  logic        v;
  logic        e;
  logic [15:0] pat[3] = '{16'h0000, 16'h00FF, 16'h003C};
  logic [15:0] rsn[5] = '{16'h0008, 16'h0007, 16'h000D, 16'h000B, 16'h000A};
  owd_row_t    rows[15] = '{
    {1'b1, a_tmo, 16'h00C8, 16'h0000, 1'b0}, {1'b0, a_tmo, 16'h0000, 16'h00C8, 1'b0},
    {1'b1, a_mode, 16'h0001, 16'h0000, 1'b0}, {1'b0, a_mode, 16'h0000, 16'h0001, 1'b0},
    {1'b1, a_mode, 16'h0003, 16'h0000, 1'b0}, {1'b0, a_mode, 16'h0000, 16'h0001, 1'b0},
    {1'b1, a_mode, 16'h0002, 16'h0000, 1'b0}, {1'b0, a_mode, 16'h0000, 16'h0002, 1'b0},
    {1'b0, a_rsn, 16'h0000, 16'h0000, 1'b0}, {1'b1, a_rsn, 16'h1234, 16'h0000, 1'b1},
    {1'b0, a_cmd, 16'h0000, 16'h0000, 1'b1}, {1'b1, a_cmd, 16'h0030, 16'h0000, 1'b1},
    {1'b1, a_cmd, 16'h0001, 16'h0000, 1'b1}, {1'b1, a_sts, 16'h0000, 16'h0000, 1'b1},
    {1'b0, a_sts, 16'h0000, 16'h0000, 1'b0}};

  owd_output_watchdog #(.CYC_PER_MS(4), .OUT_W(8)) u_owd_output_watchdog (
    .ref_clk(ref_clk), .rstn(rstn), .req(req), .auto_confirm(auto_confirm), .evt(evt),
    .diag_bits(diag_bits), .io_warn_set(io_warn_set), .rdata(rdata), .rvalid(rvalid),
    .access_err(access_err), .io_warn(io_warn), .out_pins(out_pins));
  owd_cli u_owd_cli (
    .ref_clk(ref_clk), .rdata(rdata), .rvalid(rvalid), .access_err(access_err), .req(req));

  task automatic print_verdict;
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    num_checks++;
    if (s !== x)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_owd_cli.xfer(1'b1, a, d, q, v, e);
  endtask : wr
  task automatic rd(input logic [15:0] a, input string nm, input logic [15:0] x);
    u_owd_cli.xfer(1'b0, a, 16'h0000, q, v, e);
    chk(nm, q, x);
  endtask : rd
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  // polls status only, so the watchdog must not be retriggered meanwhile
  task automatic wait_fail;
    n = 0;
    q = 16'h0000;
    while (q[1] !== 1'b1 && n < 600)
    begin
      u_owd_cli.xfer(1'b0, a_sts, 16'h0000, q, v, e);
      n++;
    end
    chk("expiry_polls", 16'(n >= 397 && n <= 404), 16'h0001);
    if (n >= 600)
      print_verdict();
  endtask : wait_fail

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end
  initial
  begin
    rstn = 1'b0;
    auto_confirm = 1'b0;
    evt = '0;
    diag_bits = 16'h0000;
    io_warn_set = 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      u_owd_cli.xfer(rows[i].w, rows[i].a, rows[i].d, q, v, e);
      chk("rvalid", {15'h0000, v}, {15'h0000, !rows[i].w});
      chk("access_err", {15'h0000, e}, {15'h0000, rows[i].e});
      if (!rows[i].w)
        chk("rdata", q, rows[i].q);
    end
    wr(a_mode, 16'h0001);
    wr(a_out, 16'h0055);
    tick(2);
    chk("out_pins", {8'h00, out_pins}, 16'h0055);
    wait_fail();
    tick(2);
    chk("out_pins", {8'h00, out_pins}, 16'h00FF);
    rd(a_rsn, "reason", 16'h000C);
    rd(a_sts, "status", 16'h0003);
    wr(a_out, 16'h0066);
    rd(a_sts, "status", 16'h0003);
    wr(a_cmd, 16'h0020);
    tick(2);
    chk("out_pins", {8'h00, out_pins}, 16'h0066);
    rd(a_sts, "status", 16'h0000);
    wait_fail();
    @(posedge ref_clk);
    auto_confirm <= 1'b1;
    wr(a_out, 16'h003C);
    rd(a_sts, "status", 16'h0000);
    for (int m = 0; m < 3; m++)
    begin
      wr(a_mode, 16'(m));
      wr(a_cmd, 16'h0010);
      tick(2);
      chk("out_pins", {8'h00, out_pins}, pat[m]);
      rd(a_rsn, "reason", 16'h0009);
      wr(a_out, 16'h003C);
    end
    for (int k = 0; k < 5; k++)
    begin
      @(posedge ref_clk);
      evt <= owd_evt_t'(5'h01 << k);
      @(posedge ref_clk);
      evt <= '0;
      rd(a_rsn, "reason", rsn[k]);
      wr(a_out, 16'h003C);
    end
    wr(a_tmo, 16'h0000);
    wr(a_out, 16'h0011);
    tick(900);
    rd(a_sts, "status", 16'h0000);
    @(posedge ref_clk);
    io_warn_set <= 1'b1;
    @(posedge ref_clk);
    io_warn_set <= 1'b0;
    tick(4);
    chk("io_warn", {15'h0000, io_warn}, 16'h0001);
    rd(a_sts, "status", 16'h0001);
    wr(a_cmd, 16'h0080);
    chk("io_warn", {15'h0000, io_warn}, 16'h0000);
    @(posedge ref_clk);
    diag_bits <= 16'h0004;
    tick(4);
    rd(a_sts, "status", 16'h0001);
    @(posedge ref_clk);
    rstn <= 1'b0;
    diag_bits <= 16'h0000;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(a_mode, "mode", 16'h0000);
    print_verdict();
  end
endmodule : tb
